// *** driver_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module driver_monitor #(
    parameter int unsigned STAGES = driver_pkg::NUM_STAGES
)
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic shift_clk_i,
    input wire logic serial_i,
    input wire logic latch_load_i,
    input wire logic blank_i,
    input wire logic serial_o,
    input wire logic [driver_pkg::NUM_STAGES-1:0] drive_o
);
    import driver_pkg::*;
    // ----
    // shadow of the shift chain
    // ----
    logic [STAGES-1:0] sh_r = '0;
    logic [3:0] n_r = '0;
    always_ff @(posedge shift_clk_i)
    begin
        sh_r <= {sh_r[STAGES-2:0], serial_i};
    end
    always_ff @(posedge shift_clk_i)
    begin
        if (rst_i)
            n_r <= '0;
        else if (n_r != 4'h8)
            n_r <= n_r + 4'h1;
    end
    sequence quiet_s;
        (latch_load_i && !blank_i && !shift_clk_i)[*8];
    endsequence
    sequence keep_s;
        (!latch_load_i && !blank_i)[*8];
    endsequence
    stage_load_a: assert property (
        @(posedge shift_clk_i) disable iff (rst_i)
        n_r == 4'h8 |-> serial_o == $past(serial_i, 8)) else $error("load");
    shift_chain_a: assert property (
        @(posedge shift_clk_i) disable iff (rst_i)
        n_r == 4'h8 |-> serial_o == sh_r[STAGES-1]) else $error("chain");
    fall_quiet_a: assert property (
        @(negedge shift_clk_i) disable iff (rst_i)
        n_r == 4'h8 |-> serial_o == sh_r[STAGES-1]) else $error("fall");
    stage_count_a: assert property (
        @(posedge shift_clk_i) disable iff (rst_i)
        n_r == 4'h8 |-> serial_o == $past(sh_r[0], 7)) else $error("count");
    latch_follow_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        quiet_s ##1 quiet_s ##0 n_r == 4'h8 |-> drive_o == sh_r)
        else $error("follow");
    latch_hold_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        keep_s ##1 keep_s |-> $stable(drive_o)) else $error("hold");
    blank_off_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        blank_i[*8] |-> drive_o == DRIVE_OFF) else $error("blank");
    drive_tail_a: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        quiet_s ##1 quiet_s ##0 n_r == 4'h8 |-> drive_o[7] == serial_o)
        else $error("tail");
endmodule

`default_nettype wire

// *** driver_pkg.sv ***
package driver_pkg;

    // ----------------------------------------
    // structure
    // ----------------------------------------
    localparam int unsigned NUM_STAGES = 8;
    localparam int unsigned BUF_DEPTH = 2;

    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    localparam int unsigned PIN_SYNC_DEPTH = 3;
    localparam int unsigned RST_SYNC_DEPTH = 2;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [NUM_STAGES-1:0] WORD_RESET = 8'h00;
    localparam logic [NUM_STAGES-1:0] DRIVE_OFF = 8'h00;

endpackage

// *** host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module host_model
(
    input wire logic ref_clk_i,
    output logic shift_clk_o,
    output logic serial_o,
    output logic latch_load_o,
    output logic blank_o
);
    // ----
    // host pins
    // ----
    initial
    begin
        shift_clk_o = 1'b0;
        serial_o = 1'b0;
        latch_load_o = 1'b0;
        blank_o = 1'b0;
    end
    // msb first, so a chained word lands in order
    task automatic send(input logic [7:0] w);
        #3;
        for (int i = 7; i >= 0; i--)
        begin
            serial_o = w[i];
            #7.5 shift_clk_o = 1'b1;
            #7.5 shift_clk_o = 1'b0;
        end
        serial_o = 1'b0;
    endtask
    // blanking kept high while shifting with latch-load high
    task automatic ctl(input logic ld, input logic bl);
        @(negedge ref_clk_i);
        latch_load_o = ld;
        blank_o = bl;
    endtask
endmodule

`default_nettype wire

// *** serial_in_latched_driver.sv ***
// Summary of operation
// [R01] eight shift stages, eight latches, eight drivers, one of each per stage
// [R02] rising shift clock loads the serial input into stage one
// [R03] rising shift clock moves each stage on; stage eight feeds serial output
// [R04] falling shift clock edge changes nothing
// [R05] latch-load high: latches follow the shift stages continuously; here they take settled words, buffered older ones first
// [R06] latch-load low: latches hold whatever the shift register does
// [R07] blanking high turns all drivers off, latches and register untouched
// [R08] blanking low: each driver shows its latch
// [R09] host keeps blanking high while shifting if latch-load is tied high
// [R10] host may chain devices, serial output into next serial input
`timescale 1ns/1ps
`default_nettype none

module serial_in_latched_driver #(
    parameter int unsigned STAGES = driver_pkg::NUM_STAGES
)
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic shift_clk_i,
    input wire logic serial_i,
    input wire logic latch_load_i,
    input wire logic blank_i,
    output logic serial_o,
    output logic [driver_pkg::NUM_STAGES-1:0] drive_o
);
    import driver_pkg::*;

    generate
        if (STAGES != NUM_STAGES || NUM_STAGES < 2 || PIN_SYNC_DEPTH != 3)
        begin : g_bad_cfg
            $error("stage count or synchroniser depth not supported");
        end
    endgenerate

    // ----------------------------------------
    // link domain: shift register
    // ----------------------------------------
    // bit 0 is stage one, bit STAGES-1 is stage eight; no reset here, so
    // no shift edge is ever swallowed, and serial_o is unknown until
    // eight bits have gone in
    logic [NUM_STAGES-1:0] shift_r;

    // only the rising edge is used [R04]
    genvar s;
    generate
        for (s = 0; s < NUM_STAGES; s++)
        begin : g_stage
            if (s == 0)
            begin : g_first
                always_ff @(posedge shift_clk_i)
                begin
                    shift_r[s] <= serial_i; // [R01] [R02]
                end
            end
            else
            begin : g_next
                always_ff @(posedge shift_clk_i)
                begin
                    shift_r[s] <= shift_r[s-1]; // [R01] [R03]
                end
            end
        end
    endgenerate

    // cascade output for chaining [R03] [R10]
    assign serial_o = shift_r[NUM_STAGES-1];

    // ----------------------------------------
    // crossing: shift word
    // ----------------------------------------
    logic [NUM_STAGES-1:0] word_sync_r [PIN_SYNC_DEPTH];
    logic [NUM_STAGES-1:0] word_flt_r;
    logic [NUM_STAGES-1:0] last_push_r;

    always_ff @(posedge ref_clk_i)
    begin
        word_sync_r[0] <= shift_r;
        word_sync_r[1] <= word_sync_r[0];
        word_sync_r[2] <= word_sync_r[1];
    end

    // the word is taken only when two samples agree, so a sample caught
    // while the stages move is dropped
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            word_flt_r <= WORD_RESET;
        else if (word_sync_r[1] == word_sync_r[2])
            word_flt_r <= word_sync_r[2];
    end

    // ----------------------------------------
    // crossing: control pins
    // ----------------------------------------
    localparam int unsigned PINS = 2;
    localparam int unsigned LOAD_BIT = 0;
    localparam int unsigned BLANK_BIT = 1;
    logic [PINS-1:0] pin_raw;
    logic [PINS-1:0] pin_sync_r [PIN_SYNC_DEPTH];
    logic [PINS-1:0] pin_flt_r;

    assign pin_raw = {blank_i, latch_load_i};

    always_ff @(posedge ref_clk_i)
    begin
        pin_sync_r[0] <= pin_raw;
        pin_sync_r[1] <= pin_sync_r[0];
        pin_sync_r[2] <= pin_sync_r[1];
    end

    // blanking resets high so the drivers stay off until a pin is seen
    genvar p;
    generate
        for (p = 0; p < PINS; p++)
        begin : g_pin
            always_ff @(posedge ref_clk_i)
            begin
                if (rst_i)
                    pin_flt_r[p] <= (p == BLANK_BIT);
                else if (pin_sync_r[1][p] == pin_sync_r[2][p])
                    pin_flt_r[p] <= pin_sync_r[2][p];
            end
        end
    endgenerate

    // ----------------------------------------
    // two-entry buffer
    // ----------------------------------------
    word_if #(.WIDTH(NUM_STAGES)) fill_w ();
    word_if #(.WIDTH(NUM_STAGES)) drain_w ();

    // a settled word that differs from the last one pushed is offered;
    // while the buffer is full it waits here, always the newest
    assign fill_w.valid = (word_flt_r != last_push_r);
    assign fill_w.data = word_flt_r;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            last_push_r <= WORD_RESET;
        else if (fill_w.valid && fill_w.ready)
            last_push_r <= word_flt_r;
    end

    word_buffer #(
        .WIDTH(NUM_STAGES),
        .DEPTH(BUF_DEPTH)
    ) u_buffer (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .in_p(fill_w),
        .out_p(drain_w)
    );

    // ----------------------------------------
    // latches
    // ----------------------------------------
    logic [NUM_STAGES-1:0] latch_r;

    // draining stalls while latch-load is low, so the buffer fills
    assign drain_w.ready = pin_flt_r[LOAD_BIT]; // [R05] [R06]

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            latch_r <= WORD_RESET;
        else if (drain_w.valid && drain_w.ready)
            latch_r <= drain_w.data; // [R05]
    end

    // ----------------------------------------
    // output drivers
    // ----------------------------------------
    logic [NUM_STAGES-1:0] drive_r;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            drive_r <= DRIVE_OFF;
        else if (pin_flt_r[BLANK_BIT])
            drive_r <= DRIVE_OFF; // [R07]
        else
            drive_r <= latch_r; // [R08]
    end

    assign drive_o = drive_r;

endmodule

`default_nettype wire

// *** serial_in_latched_driver_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module serial_in_latched_driver_tb;
    import driver_pkg::*;
    // ----
    // bench
    // ----
    logic clk;
    logic rst;
    logic sclk;
    logic sin;
    logic ld;
    logic bl;
    logic sout;
    logic [NUM_STAGES-1:0] drv;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    serial_in_latched_driver i_dut (.ref_clk_i(clk), .rst_i(rst),
        .shift_clk_i(sclk), .serial_i(sin), .latch_load_i(ld),
        .blank_i(bl), .serial_o(sout), .drive_o(drv));
    host_model i_host (.ref_clk_i(clk), .shift_clk_o(sclk),
        .serial_o(sin), .latch_load_o(ld), .blank_o(bl));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("fails %0d checks %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic settle;
        repeat (20) @(negedge clk);
    endtask
    task automatic t_follow;
        i_host.send(8'hA5);
        i_host.ctl(1'b1, 1'b0);
        settle();
        check(drv, 8'hA5);
        check({7'h0, sout}, 8'h01);
    endtask
    task automatic t_buffer;
        i_host.ctl(1'b0, 1'b0);
        i_host.send(8'h11);
        settle();
        i_host.send(8'h22);
        settle();
        i_host.send(8'h3C);
        settle();
        check(drv, 8'hA5);
        check({7'h0, sout}, 8'h00);
        i_host.ctl(1'b1, 1'b0);
        settle();
        check(drv, 8'h3C);
    endtask
    task automatic t_blank;
        i_host.ctl(1'b0, 1'b1);
        i_host.send(8'h66);
        settle();
        check(drv, DRIVE_OFF);
        i_host.ctl(1'b0, 1'b0);
        settle();
        check(drv, 8'h3C);
        i_host.ctl(1'b1, 1'b0);
        settle();
        check(drv, 8'h66);
    endtask
    task automatic t_bypass;
        i_host.ctl(1'b1, 1'b1);
        i_host.send(8'h81);
        i_host.send(8'h7E);
        settle();
        check(drv, DRIVE_OFF);
        i_host.ctl(1'b1, 1'b0);
        settle();
        check(drv, 8'h7E);
    endtask
    initial
    begin
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_follow();
        t_buffer();
        t_blank();
        t_bypass();
        give_verdict();
    end
endmodule

bind serial_in_latched_driver driver_monitor #(.STAGES(STAGES)) i_mon (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .shift_clk_i(shift_clk_i),
    .serial_i(serial_i),
    .latch_load_i(latch_load_i),
    .blank_i(blank_i),
    .serial_o(serial_o),
    .drive_o(drive_o)
);

`default_nettype wire

// *** word_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none

module word_buffer #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    word_if.snk in_p,
    word_if.src out_p
);
    import driver_pkg::*;

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    generate
        if (DEPTH < 2 || WIDTH < 1)
        begin : g_bad_cfg
            $error("word_buffer needs DEPTH >= 2 and WIDTH >= 1");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // ----------------------------------------
    // handshake
    // ----------------------------------------
    assign in_p.ready = (count_r != FULL_COUNT);
    assign out_p.valid = (count_r != '0);
    assign out_p.data = mem_r[rd_ptr_r];
    assign push = in_p.valid && in_p.ready;
    assign pop = out_p.valid && out_p.ready;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    genvar e;
    generate
        for (e = 0; e < DEPTH; e++)
        begin : g_entry
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    mem_r[e] <= '0;
                else if (push && wr_ptr_r == AW'(e))
                    mem_r[e] <= in_p.data;
            end
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wr_ptr_r <= '0;
        else if (push)
            wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rd_ptr_r <= '0;
        else if (pop)
            rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            count_r <= '0;
        else if (push && !pop)
            count_r <= count_r + 1'b1;
        else if (pop && !push)
            count_r <= count_r - 1'b1;
    end

endmodule

`default_nettype wire

// *** word_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface word_if #(
    parameter int unsigned WIDTH = 8
);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;

    modport src
    (
        output valid,
        output data,
        input ready
    );

    modport snk
    (
        input valid,
        input data,
        output ready
    );
endinterface

`default_nettype wire
